// ### rtl/qbp_port_pair.sv
`timescale 1ns/1ps
`default_nettype none

module qbp_port_pair
    import qbp_pkg::*;
#(
    parameter int WIDTH = QBP_WIDTH,
    parameter int BOOST_CYCLES = QBP_BOOST_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    // Core write/read of latches
    input wire logic upper_wr_i,
    input wire logic [WIDTH-1:0] upper_wdata_i,
    input wire logic special_wr_i,
    input wire logic [WIDTH-1:0] special_wdata_i,
    output logic [WIDTH-1:0] upper_latch_o,
    output logic [WIDTH-1:0] special_latch_o,
    output logic [WIDTH-1:0] upper_pin_level_o,
    output logic [WIDTH-1:0] special_pin_level_o,
    // External memory cycle from core
    input wire logic ext_cycle_i,
    input wire logic [WIDTH-1:0] high_address_byte_i,
    // Alternate functions
    input wire qbp_alt_out_t alt_out_i,
    output qbp_alt_in_t alt_in_o,
    // Code source select pin
    input wire logic external_code_select_n_i,
    output logic fetch_external_o,
    // Pins
    input wire logic [WIDTH-1:0] upper_address_port_pins_i,
    output qbp_drive_t upper_address_port_pins_drive_o,
    input wire logic [WIDTH-1:0] special_function_port_pins_i,
    output qbp_drive_t special_function_port_pins_drive_o
);

    logic [WIDTH-1:0] upper_latch_q;
    logic [WIDTH-1:0] special_latch_q;
    logic [WIDTH-1:0] upper_level;
    logic [WIDTH-1:0] special_level;
    logic [WIDTH-1:0] special_alt;
    logic [WIDTH-1:0] upper_sync;
    logic [WIDTH-1:0] special_sync;
    logic sel_sync1_q;
    logic sel_sync2_q;
    logic fetch_ext_q;

    // ------------------------------------------------------------
    // Port latches
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            upper_latch_q <= QBP_LATCH_RESET;
        end else if (upper_wr_i) begin
            upper_latch_q <= upper_wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            special_latch_q <= QBP_LATCH_RESET;
        end else if (special_wr_i) begin
            special_latch_q <= special_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Level each pin should take
    // ------------------------------------------------------------
    always_comb begin
        special_alt = '1;
        special_alt[QBP_BIT_TXD] = alt_out_i.serial0_transmit_out;
        special_alt[QBP_BIT_WRS] = alt_out_i.write_strobe_n;
        special_alt[QBP_BIT_RDS] = alt_out_i.read_strobe_n;
    end

    // Address wins only while the external cycle lasts
    assign upper_level = ext_cycle_i ? high_address_byte_i
        : upper_latch_q;
    assign special_level = special_latch_q & special_alt;

    // ------------------------------------------------------------
    // Per-pin drivers
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        qbp_pin_cell #(
            .BOOST_CYCLES(BOOST_CYCLES)
        ) u_upper (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .level_i(upper_level[i]),
            .pin_i(upper_address_port_pins_i[i]),
            .pull_down_o(upper_address_port_pins_drive_o.pull_down[i]),
            .strong_up_o(upper_address_port_pins_drive_o.strong_up[i]),
            .weak_up_o(upper_address_port_pins_drive_o.weak_up[i]),
            .pin_sync_o(upper_sync[i])
        );
        qbp_pin_cell #(
            .BOOST_CYCLES(BOOST_CYCLES)
        ) u_special (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .level_i(special_level[i]),
            .pin_i(special_function_port_pins_i[i]),
            .pull_down_o(special_function_port_pins_drive_o.pull_down[i]),
            .strong_up_o(special_function_port_pins_drive_o.strong_up[i]),
            .weak_up_o(special_function_port_pins_drive_o.weak_up[i]),
            .pin_sync_o(special_sync[i])
        );
    end

    // ------------------------------------------------------------
    // Reads and alternate inputs
    // ------------------------------------------------------------
    assign upper_latch_o = upper_latch_q;
    assign special_latch_o = special_latch_q;
    assign upper_pin_level_o = upper_sync;
    assign special_pin_level_o = special_sync;

    always_comb begin
        alt_in_o.serial0_receive_in = special_sync[QBP_BIT_RXD];
        alt_in_o.ext_irq_line_0 = special_sync[QBP_BIT_IRQ0];
        alt_in_o.ext_irq_line_1 = special_sync[QBP_BIT_IRQ1];
        alt_in_o.timer0_count_in = special_sync[QBP_BIT_TMR0];
        alt_in_o.timer1_count_in = special_sync[QBP_BIT_TMR1];
    end

    // ------------------------------------------------------------
    // Code source select
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sel_sync1_q <= 1'b1;
            sel_sync2_q <= 1'b1;
            fetch_ext_q <= 1'b0;
        end else begin
            sel_sync1_q <= external_code_select_n_i;
            sel_sync2_q <= sel_sync1_q;
            fetch_ext_q <= !sel_sync2_q;
        end
    end

    assign fetch_external_o = fetch_ext_q;

endmodule : qbp_port_pair

`default_nettype wire

// ### rtl/qbp_pkg.sv
package qbp_pkg;

    // ------------------------------------------------------------
    // Port geometry and reset values
    // ------------------------------------------------------------
    localparam int QBP_WIDTH = 8;
    localparam logic [7:0] QBP_LATCH_RESET = 8'hff;

    // ------------------------------------------------------------
    // Transition driver timing
    // ------------------------------------------------------------
    localparam int QBP_CLK_MHZ = 125;
    localparam int QBP_BOOST_NS = 16;
    localparam int QBP_BOOST_CYCLES =
        ((QBP_BOOST_NS * QBP_CLK_MHZ + 999) / 1000) < 1 ? 1 :
        ((QBP_BOOST_NS * QBP_CLK_MHZ + 999) / 1000);

    // ------------------------------------------------------------
    // Second port bit positions
    // ------------------------------------------------------------
    localparam int QBP_BIT_RXD = 0;
    localparam int QBP_BIT_TXD = 1;
    localparam int QBP_BIT_IRQ0 = 2;
    localparam int QBP_BIT_IRQ1 = 3;
    localparam int QBP_BIT_TMR0 = 4;
    localparam int QBP_BIT_TMR1 = 5;
    localparam int QBP_BIT_WRS = 6;
    localparam int QBP_BIT_RDS = 7;

    // ------------------------------------------------------------
    // Pin drive bundle
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pull_down;
        logic [7:0] strong_up;
        logic [7:0] weak_up;
    } qbp_drive_t;

    // ------------------------------------------------------------
    // Second port alternate outputs, all default high
    // ------------------------------------------------------------
    typedef struct packed {
        logic serial0_transmit_out;
        logic write_strobe_n;
        logic read_strobe_n;
    } qbp_alt_out_t;

    typedef struct packed {
        logic serial0_receive_in;
        logic ext_irq_line_0;
        logic ext_irq_line_1;
        logic timer0_count_in;
        logic timer1_count_in;
    } qbp_alt_in_t;

endpackage : qbp_pkg

// ### rtl/qbp_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module qbp_pin_cell
    import qbp_pkg::*;
#(
    parameter int BOOST_CYCLES = QBP_BOOST_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic level_i,
    input wire logic pin_i,
    output logic pull_down_o,
    output logic strong_up_o,
    output logic weak_up_o,
    output logic pin_sync_o
);

    localparam int CW = $clog2(BOOST_CYCLES + 1);

    logic level_q;
    logic [CW-1:0] boost_q;
    logic sync1_q;
    logic sync2_q;
    logic pd_q;
    logic su_q;

    // ------------------------------------------------------------
    // Previous level and transition counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            level_q <= 1'b1;
        end else begin
            level_q <= level_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            boost_q <= '0;
        end else if (level_i && !level_q) begin
            boost_q <= CW'(BOOST_CYCLES);
        end else if (!level_i) begin
            boost_q <= '0;
        end else if (boost_q != '0) begin
            boost_q <= boost_q - CW'(1);
        end
    end

    // ------------------------------------------------------------
    // Registered drive outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pd_q <= 1'b0;
            su_q <= 1'b0;
        end else begin
            pd_q <= !level_i;
            su_q <= (level_i && !level_q) ||
                (level_i && boost_q > CW'(1));
        end
    end

    assign pull_down_o = pd_q;
    assign strong_up_o = su_q;
    assign weak_up_o = !pd_q;

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    assign pin_sync_o = sync2_q;

endmodule : qbp_pin_cell

`default_nettype wire

// ### tb/qbp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module qbp_pin_model
    import qbp_pkg::*;
(
    input wire qbp_drive_t up_i,
    input wire qbp_drive_t sp_i,
    input wire logic [7:0] ext_low_i,
    output logic [7:0] up_pins_o,
    output logic [7:0] sp_pins_o
);
    // Strong low wins, board low beats weak and strong pull-up
    assign up_pins_o = ~up_i.pull_down & ~ext_low_i
        & (up_i.strong_up | up_i.weak_up);
    assign sp_pins_o = ~sp_i.pull_down & ~ext_low_i
        & (sp_i.strong_up | sp_i.weak_up);
endmodule : qbp_pin_model
`default_nettype wire

// ### tb/qbp_port_pair_chk.sv
`timescale 1ns/1ps
`default_nettype none
module qbp_port_pair_chk
    import qbp_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ext_cycle_i,
    input wire logic [7:0] high_address_byte_i,
    input wire logic [7:0] upper_latch_o,
    input wire logic [7:0] special_latch_o,
    input wire logic [7:0] upper_pin_level_o,
    input wire logic [7:0] special_pin_level_o,
    input wire qbp_alt_out_t alt_out_i,
    input wire qbp_alt_in_t alt_in_o,
    input wire logic external_code_select_n_i,
    input wire logic fetch_external_o,
    input wire logic [7:0] upper_address_port_pins_i,
    input wire qbp_drive_t upper_address_port_pins_drive_o,
    input wire qbp_drive_t special_function_port_pins_drive_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire qbp_drive_t u = upper_address_port_pins_drive_o;
    wire qbp_drive_t s = special_function_port_pins_drive_o;
    wire logic [7:0] m = {alt_out_i.read_strobe_n, alt_out_i.write_strobe_n,
        4'hf, alt_out_i.serial0_transmit_out, 1'b1};
    wire logic [7:0] t = special_latch_o & m;
    property p_rst;
        disable iff (1'b0) reset_i |-> {u.weak_up, s.weak_up} == 16'hffff
            && {u.pull_down, u.strong_up, s.pull_down, s.strong_up} == 32'h0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset drive");
    property p_ext;
        ext_cycle_i |=> u.pull_down == ~$past(high_address_byte_i);
    endproperty
    a_ext: assert property (p_ext) else $error("address drive");
    property p_back;
        !ext_cycle_i |=> u.pull_down == ~$past(upper_latch_o);
    endproperty
    a_back: assert property (p_back)
        else $error("latch drive");
    property p_spec;
        1'b1 |=> s.pull_down == ~$past(t);
    endproperty
    a_spec: assert property (p_spec)
        else $error("alt drive");
    property p_sync;
        !$past(reset_i, 2) |->
            upper_pin_level_o == $past(upper_address_port_pins_i, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pin read");
    property p_fetch;
        !$past(reset_i, 3) |->
            fetch_external_o == !$past(external_code_select_n_i, 3);
    endproperty
    a_fetch: assert property (p_fetch) else $error("code select");
    property p_alt;
        alt_in_o == {special_pin_level_o[0], special_pin_level_o[2],
            special_pin_level_o[3], special_pin_level_o[4],
            special_pin_level_o[5]};
    endproperty
    a_alt: assert property (p_alt) else $error("alt inputs");
    property p_boost;
        $fell(u.pull_down[0]) |-> u.strong_up[0] [*2] ##1 !u.strong_up[0];
    endproperty
    a_boost: assert property (p_boost) else $error("boost length");
endmodule : qbp_port_pair_chk
bind qbp_port_pair qbp_port_pair_chk i_chk (.clk_i(clk_i), .reset_i(reset_i),
    .ext_cycle_i(ext_cycle_i), .high_address_byte_i(high_address_byte_i),
    .upper_latch_o(upper_latch_o), .special_latch_o(special_latch_o),
    .upper_pin_level_o(upper_pin_level_o),
    .special_pin_level_o(special_pin_level_o),
    .alt_out_i(alt_out_i), .alt_in_o(alt_in_o),
    .external_code_select_n_i(external_code_select_n_i),
    .fetch_external_o(fetch_external_o),
    .upper_address_port_pins_i(upper_address_port_pins_i),
    .upper_address_port_pins_drive_o(upper_address_port_pins_drive_o),
    .special_function_port_pins_drive_o(special_function_port_pins_drive_o));
`default_nettype wire

// ### tb/qbp_port_pair_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value %s expected %h seen %h", n, e, g); \
    end end
module qbp_port_pair_bench
    import qbp_pkg::*;
;
    logic clk_i = 1'b0, reset_i = 1'b0, wr = 1'b0, ext = 1'b0, sel_n = 1'b1;
    logic [7:0] ud = 8'hff, sd = 8'hff, adr = 8'h00, low = 8'h00;
    qbp_alt_out_t alt = 3'h7;
    wire logic [7:0] ul, sl, ulv, slv, upins, spins;
    wire qbp_alt_in_t ain;
    wire logic fetch;
    wire qbp_drive_t udrv, sdrv;
    int mismatches = 0, total_checks = 0, hi;
    qbp_alt_in_t ea;
    typedef struct packed {
        logic [7:0] u, s;
        logic [2:0] a;
        logic [7:0] x, ue, se;
    } qbp_row_t;
    qbp_row_t rows [6] = '{'{8'hff, 8'hff, 3'h7, 8'h00, 8'hff, 8'hff},
        '{8'h00, 8'h00, 3'h7, 8'h00, 8'h00, 8'h00},
        '{8'ha5, 8'h5a, 3'h7, 8'h0f, 8'ha0, 8'h50},
        '{8'hff, 8'hff, 3'h3, 8'h00, 8'hff, 8'hfd},
        '{8'hff, 8'hff, 3'h6, 8'h00, 8'hff, 8'h7f},
        '{8'hff, 8'hbf, 3'h0, 8'h00, 8'hff, 8'h3d}};
    always #4 clk_i = ~clk_i;
    qbp_port_pair i_qbp_port_pair (.clk_i(clk_i), .reset_i(reset_i),
        .upper_wr_i(wr), .upper_wdata_i(ud), .special_wr_i(wr),
        .special_wdata_i(sd), .upper_latch_o(ul), .special_latch_o(sl),
        .upper_pin_level_o(ulv), .special_pin_level_o(slv),
        .ext_cycle_i(ext), .high_address_byte_i(adr), .alt_out_i(alt),
        .alt_in_o(ain), .external_code_select_n_i(sel_n),
        .fetch_external_o(fetch), .upper_address_port_pins_i(upins),
        .upper_address_port_pins_drive_o(udrv),
        .special_function_port_pins_i(spins),
        .special_function_port_pins_drive_o(sdrv));
    qbp_pin_model i_qbp_pin_model (.up_i(udrv), .sp_i(sdrv), .ext_low_i(low),
        .up_pins_o(upins), .sp_pins_o(spins));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask : step
    task automatic put(input logic [7:0] u, input logic [7:0] s);
        ud = u;
        sd = s;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask : put
    initial begin
        // Raised after time zero so the reset edge is always seen
        #1 reset_i = 1'b1;
        step(10);
        `CHK("drive", 48'h0000ff0000ff, {udrv, sdrv})
        `CHK("level", 16'hffff, {ulv, slv})
        reset_i = 1'b0;
        step(1);
        foreach (rows[i]) begin
            alt = rows[i].a;
            low = rows[i].x;
            put(rows[i].u, rows[i].s);
            step(6);
            `CHK("latch", {rows[i].u, rows[i].s}, {ul, sl})
            `CHK("upper_pins", rows[i].ue, ulv)
            `CHK("special_pins", rows[i].se, slv)
            ea = {rows[i].se[0], rows[i].se[2], rows[i].se[3],
                rows[i].se[4], rows[i].se[5]};
            `CHK("alt_in", ea, ain)
        end
        put(8'h00, 8'hbf);
        step(4);
        put(8'hff, 8'hbf);
        hi = 0;
        repeat (8) begin
            @(negedge clk_i);
            hi += udrv.strong_up[0];
        end
        `CHK("boost", QBP_BOOST_CYCLES, hi)
        adr = 8'h3c;
        ext = 1'b1;
        step(4);
        `CHK("address", 8'h3c, ulv)
        ext = 1'b0;
        step(4);
        `CHK("restore", 8'hff, ulv)
        sel_n = 1'b0;
        step(5);
        `CHK("fetch", 1'b1, fetch)
        sel_n = 1'b1;
        step(5);
        `CHK("fetch", 1'b0, fetch)
        // Mid-run reset with both latches at zero
        alt = 3'h7;
        put(8'h00, 8'h00);
        step(3);
        reset_i = 1'b1;
        step(2);
        `CHK("reset_latch", 16'hffff, {ul, sl})
        `CHK("reset_drive", 48'h0000ff0000ff, {udrv, sdrv})
        reset_i = 1'b0;
        step(3);
        `CHK("after_drive", 48'h0000ff0000ff, {udrv, sdrv})
        `CHK("after_level", 16'hffff, {ulv, slv})
        print_verdict();
    end
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
endmodule : qbp_port_pair_bench
`default_nettype wire
